// [bench/czr_checker.sv]
// port assertions for the channel zero routing map
`timescale 1ns/1ps
module czr_checker (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b code
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [1:0] active_channel, // channel
	input wire logic channels_running, // running
	input wire logic [1:0] ch0_setup_index, // setup
	input wire logic [4:0] ch0_positive_route, // pos code
	input wire logic [4:0] ch0_negative_route // neg code
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both write halves taken at one edge, the usual master pattern
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_late;
		##1 !s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	AST_WR_RESP: assert property (wr_both |-> resp_late)
		else $error("write response not two edges after take");
	AST_RD_RESP: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one edge after take");
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_RD_ZERO: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 &&
		!s_axi_rdata[14] && s_axi_rdata[11:10] == 2'h0)
		else $error("reserved read bits not zero");
	AST_RESET_VAL: assert property (
		$rose(aresetn) |-> ch0_setup_index == 2'h0 &&
		ch0_positive_route == 5'h00 && ch0_negative_route == 5'h01)
		else $error("routing outputs not at reset value");
	AST_RUN_DEFAULT: assert property (
		$rose(aresetn) |=> channels_running && active_channel == 2'h0)
		else $error("channel zero not running after reset");
	// fields may only move as a write completes
	AST_FIELD_CAUSE: assert property (
		$changed({ch0_setup_index, ch0_positive_route,
		ch0_negative_route}) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("routing outputs moved without a write");
	AST_IDLE_HOLD: assert property (
		!channels_running ##1 !channels_running |->
		$stable(active_channel))
		else $error("channel moved while idle");
endmodule
bind czr_top czr_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .active_channel,
	.channels_running, .ch0_setup_index, .ch0_positive_route,
	.ch0_negative_route);

// [bench/testbench.sv]
// self-checking bench for the channel zero routing map
`timescale 1ns/1ps
module testbench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, conv_done;
	logic channels_running;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, active_channel, ch0_setup_index;
	logic [4:0] ch0_positive_route, ch0_negative_route;
	logic [15:0] v;
	int failures, n_tests;
	logic [4:0] pc [4] = '{5'h01, 5'h02, 5'h04, 5'h15};
	logic [4:0] nc [4] = '{5'h03, 5'h00, 5'h16, 5'h16};

	czr_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .conv_done, .active_channel, .channels_running,
		.ch0_setup_index, .ch0_positive_route, .ch0_negative_route);

	// free-running 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one edge of a bounded wait; a hang counts as a mismatch
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			failures++;
			end_of_test();
		end
	endtask

	// ready is raised only once valid shows, so a late master is exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			// raise once only, so the closing release is the sole write
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	// one conversion finishes, then the channel pointer is checked
	task automatic pulse(input logic [1:0] e);
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		@(posedge aclk);
		chk(32'(active_channel), 32'(e));
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, conv_done} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h0;
		failures = 0;
		n_tests = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h40, 32'h00008001, 2'h0);
		chk({25'h0, ch0_setup_index, ch0_positive_route}, 32'h0);
		chk(32'(ch0_negative_route), 32'h01);
		chk(32'({channels_running, active_channel}), 32'h4);
		// every setup code with a spread of legal input codes
		for (int i = 0; i < 4; i++) begin
			v = {2'b10, 2'(i), 2'b00, pc[i], nc[i]};
			wr(8'h40, {16'h0, v}, 4'h3, 2'h0);
			rd(8'h40, {16'h0, v}, 2'h0);
			chk(32'({ch0_setup_index, ch0_positive_route,
				ch0_negative_route}), 32'({v[13:12], v[9:0]}));
		end
		// upper lane only: clears the enable, low byte kept
		wr(8'h40, 32'h0, 4'h2, 2'h0);
		rd(8'h40, 32'h000000b6, 2'h0);
		chk(32'(channels_running), 32'h0);
		wr(8'h40, 32'h00008000, 4'h2, 2'h0);
		// the printed offset is an index, so byte 0x10 is unmapped
		wr(8'h10, 32'h1, 4'hf, 2'h2);
		rd(8'h10, 32'h0, 2'h2);
		rd(8'h40, 32'h000080b6, 2'h0);
		wr(8'h44, 32'h4, 4'hf, 2'h0);
		pulse(2'h2);
		pulse(2'h0);
		rd(8'h48, 32'h10, 2'h0);
		end_of_test();
	end
endmodule

// [common/czr_pkg.sv]
// constants and types shared by the channel zero routing map files
package czr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_CH = 4;

	// channel zero routing register: printed offset kept as index
	localparam logic [ADDR_W-1:0] ROUTING_IDX = 8'h10;
	localparam logic [ADDR_W-1:0] ROUTING_ADDR = 8'(ROUTING_IDX * 4);
	// extra enables for channels one to three, and sequencer status
	localparam logic [ADDR_W-1:0] OTHER_EN_ADDR = 8'h44;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h48;

	localparam logic [REG_W-1:0] ROUTING_RESET = 16'h8001;
	// bits 14 and 11:10 never store, so they always read zero
	localparam logic [REG_W-1:0] ROUTING_WMASK = 16'hb3ff;
	localparam logic [2:0] OTHER_EN_RESET = 3'h0;

	// field positions inside the routing register
	localparam int ENABLE_BIT = 15;
	localparam int SETUP_LSB = 12;
	localparam int SETUP_W = 2;
	localparam int POS_LSB = 5;
	localparam int NEG_LSB = 0;
	localparam int INPUT_W = 5;

	// status register fields
	localparam int STAT_CH_LSB = 0;
	localparam int STAT_RUN_BIT = 4;

	// input selection codes; anything else is reserved
	localparam logic [INPUT_W-1:0] IN_AIN0 = 5'h00;
	localparam logic [INPUT_W-1:0] IN_AIN1 = 5'h01;
	localparam logic [INPUT_W-1:0] IN_AIN2 = 5'h02;
	localparam logic [INPUT_W-1:0] IN_AIN3 = 5'h03;
	localparam logic [INPUT_W-1:0] IN_AIN4 = 5'h04;
	localparam logic [INPUT_W-1:0] IN_REF_POS = 5'h15;
	localparam logic [INPUT_W-1:0] IN_REF_NEG = 5'h16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		SQ_IDLE = 1'b0,
		SQ_RUN = 1'b1
	} czr_seq_state_t;
endpackage

// [common/czr_seq_if.sv]
// link between the register bank and the channel sequencer
`timescale 1ns/1ps
interface czr_seq_if;
	logic [czr_pkg::NUM_CH-1:0] enables;
	logic conv_done;
	logic [1:0] active_ch;
	logic active_valid;

	modport ctrl (
		output enables,
		output conv_done,
		input active_ch,
		input active_valid
	);
	modport seq (
		input enables,
		input conv_done,
		output active_ch,
		output active_valid
	);
endinterface

// [core/czr_seq.sv]
// channel sequencer: steps round the enabled channels
`timescale 1ns/1ps
module czr_seq (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	czr_seq_if.seq sq // enables in, active channel out
);
	typedef struct packed {
		czr_pkg::czr_seq_state_t state;
		logic [1:0] ch;
	} czr_seq_st_t;

	localparam czr_seq_st_t SEQ_RESET = '{state: czr_pkg::SQ_IDLE, ch: 2'h0};

	czr_seq_st_t s_reg;
	czr_seq_st_t s_next;

	// first enabled channel after cur, wrapping; cur itself comes last
	function automatic logic [1:0] czr_next_ch(input logic [1:0] cur,
		input logic [czr_pkg::NUM_CH-1:0] en);
		logic [1:0] idx;
		logic found;
		czr_next_ch = cur;
		found = 1'b0;
		idx = cur;
		for (int k = 0; k < czr_pkg::NUM_CH; k++) begin
			idx = idx + 2'h1;
			if (en[idx] && !found) begin
				czr_next_ch = idx;
				found = 1'b1;
			end
		end
	endfunction

	// advance on every finished conversion, or at once if the
	// channel in use was just disabled, so no stale channel runs on
	always_comb begin
		s_next = s_reg;
		if (sq.enables == '0) begin
			s_next.state = czr_pkg::SQ_IDLE;
		end else begin
			unique case (s_reg.state)
				czr_pkg::SQ_IDLE: begin
					s_next.ch = czr_next_ch(2'h3, sq.enables);
					s_next.state = czr_pkg::SQ_RUN;
				end
				czr_pkg::SQ_RUN: begin
					if (sq.conv_done || !sq.enables[s_reg.ch]) begin
						s_next.ch = czr_next_ch(s_reg.ch, sq.enables);
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= SEQ_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sq.active_ch = s_reg.ch;
	assign sq.active_valid = (s_reg.state == czr_pkg::SQ_RUN);
endmodule

// [core/czr_top.sv]
// channel zero routing map: axi4-lite register bank and sequencing
`timescale 1ns/1ps
//
// Function
// - The routing register is 16 bits at index 0x10 and resets to 0x8001.
// - Bit 15 enables channel zero, is read-write and resets to one.
// - With several channels enabled the channels are converted in turn.
// - Bit 14 is reserved, ignores writes and reads as zero.
// - Bits 11 to 10 are reserved, ignore writes and read as zero.
// - Bits 13 to 12 pick one of four setups for channel zero, reset 00.
// - The picked setup's four registers are applied for channel zero.
// - Bits 9 to 5 route the chosen source to the positive input, reset 0.
// - Bits 4 to 0 route the chosen source to the negative input, reset 1.
module czr_top (
	input wire logic aclk, // system clock, 100 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [czr_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // write protection, unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [czr_pkg::DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [czr_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // read protection, unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [czr_pkg::DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic conv_done, // converter finished one conversion
	output logic [1:0] active_channel, // channel being converted
	output logic channels_running, // sequencer in run state: at least one channel enabled, one cycle late
	output logic [1:0] ch0_setup_index, // setup bank for channel zero
	output logic [4:0] ch0_positive_route, // positive mux code, ch zero
	output logic [4:0] ch0_negative_route // negative mux code, ch zero
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic [czr_pkg::ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [czr_pkg::REG_W-1:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [czr_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic [czr_pkg::REG_W-1:0] channel_zero_routing;
		logic [2:0] other_enables;
	} czr_top_st_t;

	localparam czr_top_st_t TOP_RESET = '{
		awready: 1'b0,
		wready: 1'b0,
		aw_got: 1'b0,
		aw_addr: '0,
		w_got: 1'b0,
		w_data: '0,
		w_strb: 2'h0,
		bvalid: 1'b0,
		bresp: czr_pkg::RESP_OKAY,
		arready: 1'b0,
		rvalid: 1'b0,
		rdata: '0,
		rresp: czr_pkg::RESP_OKAY,
		channel_zero_routing: czr_pkg::ROUTING_RESET,
		other_enables: czr_pkg::OTHER_EN_RESET
	};

	czr_top_st_t s_reg;
	czr_top_st_t s_next;
	logic [czr_pkg::REG_W-1:0] lane_mask;
	logic [czr_pkg::REG_W-1:0] status_word;

	czr_seq_if sq_if ();

	czr_seq u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.sq(sq_if.seq)
	);

	// channel zero joins the sequence through its own enable bit
	assign sq_if.enables = {s_reg.other_enables,
		s_reg.channel_zero_routing[czr_pkg::ENABLE_BIT]};
	assign sq_if.conv_done = conv_done;

	// byte strobes widened to a bit mask over the low two lanes
	assign lane_mask = {{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};

	// sequencer state as software sees it
	always_comb begin
		status_word = '0;
		status_word[czr_pkg::STAT_CH_LSB +: 2] = sq_if.active_ch;
		status_word[czr_pkg::STAT_RUN_BIT] = sq_if.active_valid;
	end

	// address and data are taken independently and in either order;
	// the write lands only once both are held and no response waits
	always_comb begin
		logic [czr_pkg::REG_W-1:0] wmask;
		wmask = '0;
		s_next = s_reg;
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata[czr_pkg::REG_W-1:0];
			s_next.w_strb = s_axi_wstrb[1:0];
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = czr_pkg::RESP_OKAY;
			unique case (s_reg.aw_addr)
				czr_pkg::ROUTING_ADDR: begin
					// reserved bits drop out of the mask, so
					// a careless write cannot set them
					wmask = lane_mask & czr_pkg::ROUTING_WMASK;
					// codes are stored as written; reserved
					// input codes route nowhere downstream
					s_next.channel_zero_routing =
						(s_reg.channel_zero_routing & ~wmask) |
						(s_reg.w_data & wmask);
				end
				czr_pkg::OTHER_EN_ADDR: begin
					if (s_reg.w_strb[0]) begin
						s_next.other_enables = s_reg.w_data[3:1];
					end
				end
				czr_pkg::STATUS_ADDR: begin
					s_next.bresp = czr_pkg::RESP_OKAY;
				end
				default: begin
					s_next.bresp = czr_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;

		// reads answer one cycle after the address is taken
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = czr_pkg::RESP_OKAY;
			s_next.rdata = '0;
			unique case (s_axi_araddr)
				czr_pkg::ROUTING_ADDR: begin
					s_next.rdata[czr_pkg::REG_W-1:0] =
						s_reg.channel_zero_routing;
				end
				czr_pkg::OTHER_EN_ADDR: begin
					s_next.rdata[3:1] = s_reg.other_enables;
				end
				czr_pkg::STATUS_ADDR: begin
					s_next.rdata[czr_pkg::REG_W-1:0] = status_word;
				end
				default: begin
					s_next.rresp = czr_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.arready = !s_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= TOP_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// bus outputs straight from the state flops
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;

	// the setup index selects which of the four setup banks (setup,
	// filter, offset, gain) the converter loads for channel zero;
	// the fields are driven always, the converter uses them when
	// active_channel is zero and channels_running is high
	assign ch0_setup_index = s_reg.channel_zero_routing[
		czr_pkg::SETUP_LSB +: czr_pkg::SETUP_W];
	assign ch0_positive_route = s_reg.channel_zero_routing[
		czr_pkg::POS_LSB +: czr_pkg::INPUT_W];
	assign ch0_negative_route = s_reg.channel_zero_routing[
		czr_pkg::NEG_LSB +: czr_pkg::INPUT_W];
	assign active_channel = sq_if.active_ch;
	assign channels_running = sq_if.active_valid;
endmodule
